// file: tcc_pkg.sv
// Purpose: Shared constants and types for the tape cassette I/O protect controller.
// Assumes: One 40 MHz clock; all inputs synchronous to it.
// Notes:   Command classes are shared with the response unit; transport states are used by the controller only.
`default_nettype none

package tcc_pkg;

  // ----------------------------------------------------------------------
  // Addressing and switch layout
  // ----------------------------------------------------------------------
  localparam int          ADDR_W          = 4;
  localparam logic [3:0]  STD_EQUIP_ADDR  = 4'h7;  // Standard installed address.
  localparam int          SW_AUTO_REWIND  = 0;     // First control segment.
  localparam int          SW_PROTECT      = 2;     // Third control segment.
  localparam int          CTRL_SW_W       = 4;

  // ----------------------------------------------------------------------
  // Command classes and function codes
  // ----------------------------------------------------------------------
  localparam logic [1:0]  CMD_FUNCTION    = 2'h0;
  localparam logic [1:0]  CMD_STATUS      = 2'h1;
  localparam logic [1:0]  CMD_DATA        = 2'h2;
  localparam logic [1:0]  CMD_NONE        = 2'h3;

  localparam logic [2:0]  FN_STOP         = 3'h0;
  localparam logic [2:0]  FN_FORWARD      = 3'h1;
  localparam logic [2:0]  FN_REVERSE      = 3'h2;
  localparam logic [2:0]  FN_REWIND       = 3'h3;

  // Status word bit positions.
  localparam int          ST_READY        = 0;
  localparam int          ST_SIDE_B       = 1;
  localparam int          ST_AT_BOT       = 2;
  localparam int          ST_MOVING       = 3;
  localparam int          STATUS_W        = 8;

  // ----------------------------------------------------------------------
  // Transport motion states
  // ----------------------------------------------------------------------
  typedef enum logic [3:0] {
    TCC_IDLE    = 4'h1,
    TCC_FWD     = 4'h2,
    TCC_REV     = 4'h4,
    TCC_REWIND  = 4'h8
  } tcc_motion_type;

endpackage : tcc_pkg

`default_nettype wire

// file: tcc_resp_if.sv
// Purpose: Carries one decoded command between the controller and its response unit.
// Assumes: Same clock domain on both sides.
// Notes:   cmdValid is a one-cycle strobe.
`default_nettype none

interface tcc_resp_if;
  import tcc_pkg::*;
  logic       cmdValid;
  logic [1:0] cmdClass;
  logic       protectOn;
  logic       progProtected;
  logic       busyHold;
  logic       reply;
  logic       reject;
  logic       pending;

  modport ctrl (output cmdValid, output cmdClass, output protectOn, output progProtected,
                output busyHold, input reply, input reject, input pending);
  modport resp (input cmdValid, input cmdClass, input protectOn, input progProtected,
                input busyHold, output reply, output reject, output pending);
endinterface : tcc_resp_if

`default_nettype wire

// file: tcc_resp.sv
// Purpose: Decides reply or reject for each addressed command.
// Assumes: A new command is not issued while one is pending.
// Notes:   One answer pulse per command unless master clear abandons a pending one; busy only delays a reply.
`default_nettype none

module tcc_resp
  import tcc_pkg::*;
(
  // Clock and reset.
  input  wire logic clk,
  input  wire logic resetn,
  // Master clear from the processor.
  input  wire logic masterClear,
  // Command link.
  tcc_resp_if.resp  rif
);

  logic pendQ;
  logic pendD;

  // ----------------------------------------------------------------------
  // Protect decision
  // ----------------------------------------------------------------------
  // A status request is never refused; the protect check only applies when enabled.
  wire isStatus   = (rif.cmdClass == CMD_STATUS);                            // R6
  wire mustReject = rif.protectOn && !rif.progProtected && !isStatus;        // R4 R5 R7
  wire startCmd   = rif.cmdValid && !pendQ;

  // A reply waits while any other internal condition holds it off.
  // Only an accepted command can go pending, so a held reply never needs a reject check.
  assign rif.reject  = startCmd && mustReject;                               // R13
  assign rif.reply   = ((startCmd && !mustReject) || pendQ) && !rif.busyHold; // R8
  assign rif.pending = pendQ;

  // Pending stays set until the delayed reply goes out or master clear abandons it.
  assign pendD = masterClear ? 1'b0 :                                        // R14
                 (startCmd && !mustReject && rif.busyHold) ? 1'b1 :
                 (pendQ && rif.reply) ? 1'b0 : pendQ;

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      pendQ   <= 1'b0;
    end
    else
    begin
      pendQ   <= pendD;
    end
  end

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  property p_one_answer;
    @(posedge clk) disable iff (!resetn) !(rif.reply && rif.reject);
  endproperty
  a_one_answer: assert property (p_one_answer) else $error("reply and reject together"); // R13

  property p_status_never_rejected;
    @(posedge clk) disable iff (!resetn) (rif.cmdValid && isStatus) |-> !rif.reject;
  endproperty
  a_status_never_rejected: assert property (p_status_never_rejected) // R6
    else $error("status rejected");

  property p_unprot_accepts;
    @(posedge clk) disable iff (!resetn) (rif.cmdValid && !rif.protectOn) |-> !rif.reject;
  endproperty
  a_unprot_accepts: assert property (p_unprot_accepts) else $error("unprotected reject"); // R4

  property p_prot_rejects;
    @(posedge clk) disable iff (!resetn)
      (startCmd && rif.protectOn && !rif.progProtected && !isStatus) |-> rif.reject;
  endproperty
  a_prot_rejects: assert property (p_prot_rejects) else $error("missing reject"); // R5

  property p_busy_holds;
    @(posedge clk) disable iff (!resetn) rif.busyHold |-> !rif.reply;
  endproperty
  a_busy_holds: assert property (p_busy_holds) else $error("reply while busy"); // R8

  property p_prot_replies;
    @(posedge clk) disable iff (!resetn)
      (startCmd && rif.protectOn && rif.progProtected && !rif.busyHold) |-> rif.reply;
  endproperty
  a_prot_replies: assert property (p_prot_replies) else $error("missing reply"); // R7

  property p_mc_clears;
    @(posedge clk) disable iff (!resetn) masterClear |=> !pendQ;
  endproperty
  a_mc_clears: assert property (p_mc_clears) else $error("pending survived clear"); // R14

endmodule : tcc_resp // tcc_resp

`default_nettype wire

// file: tcc_ctrl.sv
// Purpose: Tape cassette controller front end: address decode, protect, motion.
// Assumes: Processor strobes one command per cycle of cmdStrobe; inputs synchronous.
// Notes:   Motion only leaves idle on a command or an auto-rewind on lid closure.
`default_nettype none

// Function
// R1: Equipment address comes from a four-bit switch field, normally seven.
// R2: Auto-rewind on: rewind to tape start whenever the lid closes.
// R3: Auto-rewind off: no rewind on lid close; rewind commands still run.
// R4: Protect off: ignore protect line, never reject any command.
// R5: Protect on and instruction unprotected: reject function and data commands.
// R6: Status requests are never rejected.
// R7: Protect on and instruction protected: reply enabled for every command.
// R8: A permitted reply waits until internal conditions allow it.
// R9: Lid open disables all transport motion and makes cassette not ready.
// R10: Cassette side is reported as one status bit.
// R11: All tape motion is commanded by controller logic only.
// R12: Control switch segments two and four have no effect.
// R13: Each addressed command gets exactly one reply or reject.
// R14: Master clear abandons any command and returns to idle.
module tcc_ctrl
  import tcc_pkg::*;
(
  // Clock and reset.
  input  wire logic                 clk,
  input  wire logic                 resetn,
  // Installation switches.
  input  wire logic [ADDR_W-1:0]    addressSelectSwitch,
  input  wire logic [CTRL_SW_W-1:0] controlOptionSwitch,
  // Main processor channel.
  input  wire logic                 masterClear,
  input  wire logic                 cmdStrobe,
  input  wire logic [ADDR_W-1:0]    cmdAddr,
  input  wire logic [1:0]           cmdClass,
  input  wire logic [2:0]           cmdFunc,
  input  wire logic                 progProtected,
  output logic                      reply,
  output logic                      reject,
  output logic [STATUS_W-1:0]       statusWord,
  // Transport sensors.
  input  wire logic                 lidClosed,
  input  wire logic                 sideB,
  input  wire logic                 atBot,
  // Transport drives.
  output logic                      motorFwd,
  output logic                      motorRev,
  output logic                      rewindActive
);

  tcc_resp_if rif ();
  tcc_motion_type stateQ;
  tcc_motion_type stateD;
  logic           lidQ;
  logic [STATUS_W-1:0] statusQ;
  logic           motorFwdQ;
  logic           motorRevQ;
  logic [2:0]     heldFuncQ;

  // ----------------------------------------------------------------------
  // Address decode and switch options
  // ----------------------------------------------------------------------
  // Segments two and four are simply never read.
  wire addrHit     = cmdStrobe && (cmdAddr == addressSelectSwitch);        // R1 R12
  wire autoRewind  = controlOptionSwitch[SW_AUTO_REWIND];
  wire protectOn   = controlOptionSwitch[SW_PROTECT];
  wire lidCloseEvt = lidClosed && !lidQ;
  wire cassReady   = lidClosed;                                            // R9

  // A function accepted this cycle, i.e. not rejected.
  wire fnAccepted  = reject ? 1'b0 : (addrHit && cmdClass == CMD_FUNCTION);

  // A held function is kept so that it still runs when its delayed reply goes out;
  // the channel lines no longer carry it by then.
  wire       fnCapture = addrHit && cmdClass == CMD_FUNCTION && !rif.pending;
  wire [2:0] heldFuncD = fnCapture ? cmdFunc : heldFuncQ;
  wire [2:0] funcSel   = rif.pending ? heldFuncQ : cmdFunc;
  wire       fnDue     = rif.reply && (rif.pending || fnAccepted);

  // ----------------------------------------------------------------------
  // Response unit hookup
  // ----------------------------------------------------------------------
  // Busy while a rewind runs, so function commands and a pending reply wait for it instead of racing it.
  assign rif.cmdValid      = addrHit && cmdClass != CMD_NONE;
  assign rif.cmdClass      = cmdClass;
  assign rif.protectOn     = protectOn;
  assign rif.progProtected = progProtected;
  assign rif.busyHold      = (stateQ == TCC_REWIND) &&
                             (rif.pending || cmdClass == CMD_FUNCTION);    // R8
  assign reply             = rif.reply;
  assign reject            = rif.reject;

  tcc_resp u_resp (
    .clk         (clk),
    .resetn      (resetn),
    .masterClear (masterClear),
    .rif         (rif)
  );

  // ----------------------------------------------------------------------
  // Motion state machine
  // ----------------------------------------------------------------------
  always_comb
  begin
    stateD = stateQ;
    unique case (stateQ)
      TCC_IDLE:
      begin
        if (lidCloseEvt && autoRewind)
          stateD = TCC_REWIND;                                             // R2 R3
      end
      TCC_FWD, TCC_REV:
      begin
        if (stateQ == TCC_REV && atBot)
          stateD = TCC_IDLE;
      end
      TCC_REWIND:
      begin
        if (atBot)
          stateD = TCC_IDLE;
      end
    endcase
    if (fnDue)
    begin
      unique case (funcSel)                                                // R11
        FN_FORWARD: stateD = TCC_FWD;
        FN_REVERSE: stateD = TCC_REV;
        FN_REWIND:  stateD = TCC_REWIND;                                   // R3
        default:    stateD = TCC_IDLE;
      endcase
    end
    if (!lidClosed || masterClear)
      stateD = TCC_IDLE;                                                   // R9 R14
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      stateQ    <= TCC_IDLE;
      lidQ      <= 1'b1;  // Closed at reset, so a shut lid gives no false close edge.
      heldFuncQ <= FN_STOP;
    end
    else
    begin
      stateQ    <= stateD;
      lidQ      <= lidClosed;
      heldFuncQ <= heldFuncD;
    end
  end

  // ----------------------------------------------------------------------
  // Drives and status, registered
  // ----------------------------------------------------------------------
  // Drives are gated by the lid again so an open lid stops the motor on the next clock edge.
  wire [STATUS_W-1:0] statusD = {{(STATUS_W-4){1'b0}},
                                 stateQ != TCC_IDLE, atBot, sideB, cassReady}; // R10

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      motorFwdQ <= 1'b0;
      motorRevQ <= 1'b0;
      statusQ   <= '0;
    end
    else
    begin
      motorFwdQ <= lidClosed && stateD == TCC_FWD;                         // R9
      motorRevQ <= lidClosed && (stateD == TCC_REV || stateD == TCC_REWIND);
      statusQ   <= statusD;
    end
  end

  assign motorFwd     = motorFwdQ;
  assign motorRev     = motorRevQ;
  assign rewindActive = (stateQ == TCC_REWIND);
  assign statusWord   = statusQ;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  property p_lid_open_stops;
    @(posedge clk) disable iff (!resetn) !lidClosed |=> (!motorFwd && !motorRev);
  endproperty
  a_lid_open_stops: assert property (p_lid_open_stops) else $error("motion with lid open"); // R9

  sequence s_close_edge;
    !lidClosed ##1 lidClosed;
  endsequence

  property p_auto_rewind;
    @(posedge clk) disable iff (!resetn)
      (s_close_edge ##0 (stateQ == TCC_IDLE && autoRewind && !masterClear && !cmdStrobe))
        |=> rewindActive;
  endproperty
  a_auto_rewind: assert property (p_auto_rewind) else $error("no auto rewind"); // R2

  property p_no_auto_rewind;
    @(posedge clk) disable iff (!resetn)
      (s_close_edge ##0 (stateQ == TCC_IDLE && !autoRewind && !cmdStrobe)) |=> !rewindActive;
  endproperty
  a_no_auto_rewind: assert property (p_no_auto_rewind) else $error("unwanted rewind"); // R3

  property p_side_status;
    @(posedge clk) disable iff (!resetn) 1'b1 |=> statusWord[ST_SIDE_B] == $past(sideB);
  endproperty
  a_side_status: assert property (p_side_status) else $error("side bit wrong"); // R10

  property p_mc_idle;
    @(posedge clk) disable iff (!resetn) masterClear |=> stateQ == TCC_IDLE;
  endproperty
  a_mc_idle: assert property (p_mc_idle) else $error("not idle after clear"); // R14

  property p_addr_only;
    @(posedge clk) disable iff (!resetn)
      (cmdStrobe && cmdAddr != addressSelectSwitch && !rif.pending) |-> !reply && !reject;
  endproperty
  a_addr_only: assert property (p_addr_only) else $error("answered foreign address"); // R1

  property p_no_free_motion;
    @(posedge clk) disable iff (!resetn)
      (stateQ == TCC_IDLE && !cmdStrobe && !rif.pending && !lidCloseEvt) |=> stateQ == TCC_IDLE;
  endproperty
  a_no_free_motion: assert property (p_no_free_motion) else $error("motion not commanded"); // R11

endmodule : tcc_ctrl // tcc_ctrl

`default_nettype wire

// file: tcc_proc_model.sv
// Purpose: Processor channel model that issues commands to the controller.
// Assumes: One command at a time; answers are sampled mid-cycle.
// Notes:   Lines that are not strobed show the inverse of their last value.
`default_nettype none

module tcc_proc_model
  import tcc_pkg::*;
(
  // Clock.
  input  wire logic         clk,
  // Command lines toward the controller.
  output logic              cmdStrobe,
  output logic [ADDR_W-1:0] cmdAddr,
  output logic [1:0]        cmdClass,
  output logic [2:0]        cmdFunc,
  output logic              progProtected,
  // Answers from the controller.
  input  wire logic         reply,
  input  wire logic         reject
);
  timeunit 1ns;
  timeprecision 1ps;

  // Idle lines from time zero.
  initial
  begin
    cmdStrobe     = 1'b0;
    cmdAddr       = 4'h0;
    cmdClass      = CMD_NONE;
    cmdFunc       = FN_STOP;
    progProtected = 1'b0;
  end

  // Looks for an answer for up to waitMax cycles unless one was already seen.
  task automatic await(input int waitMax, inout logic rep, inout logic rej);
    for (int n = 0; n < waitMax && !(rep || rej); n++)
    begin
      @(negedge clk);
      rep = reply;
      rej = reject;
    end
  endtask

  // One strobe; lines are scrambled afterwards so a stale value never helps.
  task automatic issue(input logic [ADDR_W-1:0] addr, input logic [1:0] cls,
                       input logic [2:0] fn, input logic prot, input int waitMax,
                       output logic rep, output logic rej);
    @(posedge clk);
    cmdStrobe     <= 1'b1;
    cmdAddr       <= addr;
    cmdClass      <= cls;
    cmdFunc       <= fn;
    progProtected <= prot;
    @(negedge clk);
    rep = reply;
    rej = reject;
    @(posedge clk);
    cmdStrobe     <= 1'b0;
    cmdAddr       <= ~addr;
    cmdClass      <= ~cls;
    cmdFunc       <= ~fn;
    progProtected <= ~prot;
    await(waitMax, rep, rej);
  endtask
endmodule // tcc_proc_model

`default_nettype wire

// file: tb.sv
// Purpose: Self-checking bench for the cassette controller front end.
// Assumes: The processor model issues commands; the bench drives the rest.
// Notes:   A rewind ends when the tape-start sensor rises.
`default_nettype none

`define CHK(nm, exp, got) \
  begin \
    nChecks++; \
    if ((got) !== (exp)) \
    begin \
      fails++; \
      $display("ERROR %s expected %0h seen %0h", nm, exp, got); \
    end \
  end

module tb
  import tcc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic                 clk = 1'b0;
  logic                 resetn = 1'b0;
  logic [ADDR_W-1:0]    addrSw = STD_EQUIP_ADDR;
  logic [CTRL_SW_W-1:0] ctrlSw = 4'h0;
  logic                 masterClear = 1'b0;
  logic                 lidClosed = 1'b1;
  logic                 sideB = 1'b0;
  logic                 atBot = 1'b0;
  logic                 cmdStrobe, progProtected, reply, reject;
  logic                 motorFwd, motorRev, rewindActive, rep, rej, expRej;
  logic [ADDR_W-1:0]    cmdAddr;
  logic [1:0]           cmdClass;
  logic [2:0]           cmdFunc;
  logic [STATUS_W-1:0]  statusWord;
  int                   fails = 0;
  int                   nChecks = 0;

  // 40 MHz clock.
  always #12.5 clk = ~clk;

  tcc_ctrl u_tcc_ctrl (.clk(clk), .resetn(resetn), .addressSelectSwitch(addrSw),
    .controlOptionSwitch(ctrlSw), .masterClear(masterClear), .cmdStrobe(cmdStrobe),
    .cmdAddr(cmdAddr), .cmdClass(cmdClass), .cmdFunc(cmdFunc),
    .progProtected(progProtected), .reply(reply), .reject(reject),
    .statusWord(statusWord), .lidClosed(lidClosed), .sideB(sideB), .atBot(atBot),
    .motorFwd(motorFwd), .motorRev(motorRev), .rewindActive(rewindActive));

  tcc_proc_model u_tcc_proc_model (.clk(clk), .cmdStrobe(cmdStrobe), .cmdAddr(cmdAddr),
    .cmdClass(cmdClass), .cmdFunc(cmdFunc), .progProtected(progProtected),
    .reply(reply), .reject(reject));

  // ----------------------------------------------------------------------
  // Access tasks
  // ----------------------------------------------------------------------
  // Issues one command and compares the answer pair; sampling stops at the first pulse, so a second pulse goes unseen.
  task automatic cmd(input logic [1:0] c, input logic [2:0] f, input logic p,
                     input logic eRep, input logic eRej, input logic [3:0] a = 4'h7);
    u_tcc_proc_model.issue(a, c, f, p, 3, rep, rej);
    `CHK("reply", eRep, rep)
    `CHK("reject", eRej, rej)
  endtask

  // Prints the counts and the verdict, then stops.
  task automatic conclude();
    $display("Checks %0d, mismatches %0d", nChecks, fails);
    if (fails == 0 && nChecks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // ----------------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------------
  initial
  begin
    repeat (6) @(posedge clk);
    resetn <= 1'b1;
    // Only the switch-selected address is answered.
    cmd(CMD_STATUS, FN_STOP, 1'b1, 1'b0, 1'b0, 4'h3);
    cmd(CMD_STATUS, FN_STOP, 1'b1, 1'b1, 1'b0);
    @(posedge clk);
    addrSw <= 4'hA;
    cmd(CMD_STATUS, FN_STOP, 1'b1, 1'b0, 1'b0);
    cmd(CMD_STATUS, FN_STOP, 1'b1, 1'b1, 1'b0, 4'hA);
    @(posedge clk);
    addrSw <= STD_EQUIP_ADDR;
    // Every switch setting against the function, status and data classes and both protect states.
    for (int s = 0; s < 16; s++)
    begin
      @(posedge clk);
      ctrlSw <= 4'(s);
      for (int c = 0; c < 3; c++)
        for (int p = 0; p < 2; p++)
        begin
          expRej = ((s >> SW_PROTECT) & 1) == 1 && p == 0 && 2'(c) != CMD_STATUS;
          cmd(2'(c), FN_STOP, 1'(p), ~expRej, expRej);
        end
    end
    @(posedge clk);
    ctrlSw <= 4'h0;
    // Motion follows commands only.
    cmd(CMD_FUNCTION, FN_FORWARD, 1'b1, 1'b1, 1'b0);
    repeat (2) @(negedge clk);
    `CHK("forward", 2'b11, {motorFwd, statusWord[ST_MOVING]})
    cmd(CMD_FUNCTION, FN_REVERSE, 1'b1, 1'b1, 1'b0);
    repeat (2) @(negedge clk);
    `CHK("reverse", 2'b01, {motorFwd, motorRev})
    cmd(CMD_FUNCTION, FN_STOP, 1'b1, 1'b1, 1'b0);
    repeat (2) @(negedge clk);
    `CHK("stopped", 3'b000, {motorFwd, motorRev, statusWord[ST_MOVING]})
    // Side sense shows in status.
    @(posedge clk);
    sideB <= 1'b1;
    repeat (3) @(negedge clk);
    `CHK("sideB", 2'b11, {statusWord[ST_SIDE_B], statusWord[ST_READY]})
    @(posedge clk);
    sideB <= 1'b0;
    repeat (3) @(negedge clk);
    `CHK("sideA", 1'b0, statusWord[ST_SIDE_B])
    // Open lid blocks motion and readiness.
    @(posedge clk);
    lidClosed <= 1'b0;
    u_tcc_proc_model.issue(STD_EQUIP_ADDR, CMD_FUNCTION, FN_FORWARD, 1'b1, 3, rep, rej);
    repeat (3) @(negedge clk);
    `CHK("lidOpen", 3'b000, {motorFwd, motorRev, statusWord[ST_READY]})
    // Auto-rewind off: lid closure alone leaves the tape still.
    @(posedge clk);
    lidClosed <= 1'b1;
    repeat (4) @(negedge clk);
    `CHK("noAutoRewind", 1'b0, rewindActive)
    cmd(CMD_FUNCTION, FN_REWIND, 1'b1, 1'b1, 1'b0);
    repeat (2) @(negedge clk);
    `CHK("rewinding", 1'b1, rewindActive)
    // A function reply is held while the rewind runs.
    cmd(CMD_FUNCTION, FN_STOP, 1'b1, 1'b0, 1'b0);
    @(posedge clk);
    atBot <= 1'b1;
    rep = 1'b0;
    rej = 1'b0;
    u_tcc_proc_model.await(5, rep, rej);
    `CHK("heldAnswer", 2'b10, {rep, rej})
    repeat (2) @(negedge clk);
    `CHK("rewindDone", 1'b0, rewindActive)
    `CHK("atBotStatus", 1'b1, statusWord[ST_AT_BOT])
    // Auto-rewind on: lid closure starts a rewind.
    @(posedge clk);
    ctrlSw <= 4'h1;
    atBot <= 1'b0;
    lidClosed <= 1'b0;
    repeat (3) @(posedge clk);
    lidClosed <= 1'b1;
    repeat (4) @(negedge clk);
    `CHK("autoRewind", 1'b1, rewindActive)
    // Master clear drops the held command and the rewind.
    cmd(CMD_FUNCTION, FN_FORWARD, 1'b1, 1'b0, 1'b0);
    @(posedge clk);
    masterClear <= 1'b1;
    @(posedge clk);
    masterClear <= 1'b0;
    rep = 1'b0;
    rej = 1'b0;
    u_tcc_proc_model.await(5, rep, rej);
    `CHK("cleared", 4'h0, {rewindActive, motorFwd, rep, rej})
    cmd(CMD_STATUS, FN_STOP, 1'b1, 1'b1, 1'b0);
    conclude();
  end

  // The tests need under a thousand cycles; this cuts a hang short.
  initial
  begin
    #(4000 * 25);
    fails++;
    conclude();
  end
endmodule // tb

`default_nettype wire
